// ==== rtl/ismx_top.sv ====
`timescale 1ns/1ps
// What this block does
// R1 - parallel_irq_style picks legacy or extended parallel interrupt
// R2 - parallel_bus_style picks output-only or bidirectional parallel port
// R3 - serial FIFO mode needs global permit and port enable both set
// R4 - output 0 carries irq8 inverted, 9, 10, 11, rom, reset, 14, 15
// R5 - output 1 carries irq12, keyboard, a20 gate, irq3 to irq7
// R6 - controller steps select code through all eight values repeatedly
// R7 - low pulses widened on twelve interrupt inputs
// R8 - high pulse on irq8 widened the same way
// R9 - widened span: five edges from lead or three from trail
// R10 - opposite pulses shorter than three select edges never seen
// R11 - reset request, rom input and a20 gate not widened
// R12 - stand-alone drives serial irqs on outputs, parallel irq on irq7
// R13 - stand-alone outputs enabled by modem bit 3 or control bit 4
// R14 - serial 0 route field codes including stand-alone code 15
// R15 - stand-alone code applies to both serial ports and parallel port
// R16 - serial substitution needs modem bit 4 clear and bit 3 set
// R17 - serial 1 route field uses same codes without stand-alone
// R18 - serial 1 wins over serial 0 on shared input, no or
// R19 - software writes zero upper bits, no reserved codes
// R20 - route registers at indices 2, 3, 4 through address 7
// R21 - index field chooses the register behind address 7
// R22 - parallel route needs control interrupt enable bit 4
// R23 - parallel wins over either serial on shared input, no or
// R24 - route and mode registers clear to zero on reset
module ismx_top
  import ismx_pkg::*;
#(
  parameter int LEAD = ismx_pkg::LEAD_EDGES,
  parameter int TRAIL = ismx_pkg::TRAIL_EDGES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire ismx_pkg::ismx_bus_t bus,
  input wire ismx_pkg::ismx_port_t ports,
  input wire logic [2:0] mux_select_code,
  input wire logic [15:0] irq_in_raw,
  output logic [7:0] rdata,
  output logic irq_serial_out0,
  output logic irq_serial_out0_oe,
  output logic irq_serial_out1,
  output logic irq_serial_out1_oe,
  output logic irq7_out,
  output logic irq7_oe,
  output logic parallel_irq_style,
  output logic parallel_bus_style,
  output logic [1:0] serial_fifo_mode,
  output logic ports_power_down
);
  import ismx_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [2:0] indirect_index_field_q, indirect_index_field_d;
  logic [7:0] port_mode_select_q, port_mode_select_d;
  logic [7:0] serial0_irq_route_q, serial0_irq_route_d;
  logic [7:0] serial1_irq_route_q, serial1_irq_route_d;
  logic [7:0] parallel_irq_route_q, parallel_irq_route_d;
  logic [7:0] rdata_d;
  logic data_hit;

  always_comb begin
    indirect_index_field_d = indirect_index_field_q;
    port_mode_select_d = port_mode_select_q;
    serial0_irq_route_d = serial0_irq_route_q;
    serial1_irq_route_d = serial1_irq_route_q;
    parallel_irq_route_d = parallel_irq_route_q;
    rdata_d = rdata;
    data_hit = bus.chip_sel && bus.addr == ADDR_DATA;
    if (bus.chip_sel && bus.wr && bus.addr == ADDR_INDEX) begin
      indirect_index_field_d = bus.wdata[2:0];
    end
    // R20 indirect route access
    // R21 index steers data port
    if (data_hit && bus.wr) begin
      unique case (indirect_index_field_q)
        IDX_SER0_ROUTE: serial0_irq_route_d = bus.wdata;
        IDX_SER1_ROUTE: serial1_irq_route_d = bus.wdata;
        IDX_PAR_ROUTE: parallel_irq_route_d = bus.wdata;
        IDX_MODE: port_mode_select_d = bus.wdata;
        default: ;
      endcase
    end
    if (bus.chip_sel && bus.rd) begin
      rdata_d = REG_RESET;
      if (bus.addr == ADDR_INDEX) begin
        rdata_d = {5'h00, indirect_index_field_q};
      end else if (data_hit) begin
        unique case (indirect_index_field_q)
          IDX_SER0_ROUTE: rdata_d = serial0_irq_route_q;
          IDX_SER1_ROUTE: rdata_d = serial1_irq_route_q;
          IDX_PAR_ROUTE: rdata_d = parallel_irq_route_q;
          IDX_MODE: rdata_d = port_mode_select_q;
          default: rdata_d = REG_RESET;
        endcase
      end
    end
  end

  // R24 reset clears registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      indirect_index_field_q <= 3'h0;
      port_mode_select_q <= REG_RESET;
      serial0_irq_route_q <= REG_RESET;
      serial1_irq_route_q <= REG_RESET;
      parallel_irq_route_q <= REG_RESET;
      rdata <= REG_RESET;
    end else if (ce) begin
      indirect_index_field_q <= indirect_index_field_d;
      port_mode_select_q <= port_mode_select_d;
      serial0_irq_route_q <= serial0_irq_route_d;
      serial1_irq_route_q <= serial1_irq_route_d;
      parallel_irq_route_q <= parallel_irq_route_d;
      rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // select edge detect; the select code is taken as synchronous
  logic lsb_q;
  logic tick;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lsb_q <= 1'b0;
    end else if (ce) begin
      lsb_q <= mux_select_code[0];
    end
  end
  assign tick = mux_select_code[0] && !lsb_q;

  ////////////////////////////////////////////////////////////////////
  // substitution of internal interrupts
  logic [3:0] s0_field, s1_field, p_field;
  logic standalone;
  logic s0_en, s1_en, p_en;
  logic [15:0] sub_in;

  function automatic int route_slot(input logic [3:0] code);
    int s;
    s = -1;
    unique case (code)
      RT_IRQ3: s = SLOT_IRQ3;
      RT_IRQ4: s = SLOT_IRQ4;
      RT_IRQ5: s = SLOT_IRQ5;
      RT_IRQ6: s = SLOT_IRQ6;
      RT_IRQ7: s = SLOT_IRQ7;
      RT_IRQ10: s = SLOT_IRQ10;
      RT_IRQ11: s = SLOT_IRQ11;
      RT_ROM: s = SLOT_ROM;
      RT_IRQ15: s = SLOT_IRQ15;
      default: s = -1;
    endcase
    return s;
  endfunction

  always_comb begin
    s0_field = serial0_irq_route_q[3:0] & ROUTE_FIELD_MASK;
    s1_field = serial1_irq_route_q[3:0] & ROUTE_FIELD_MASK;
    p_field = parallel_irq_route_q[3:0] & ROUTE_FIELD_MASK;
    // R14 stand-alone code
    // R15 applies to all ports
    standalone = s0_field == RT_STANDALONE;
    // R16 modem enable condition
    s0_en = !ports.modem_control_reg0[MCR_LOOP_BIT]
      && ports.modem_control_reg0[MCR_OUT2_BIT];
    s1_en = !ports.modem_control_reg1[MCR_LOOP_BIT]
      && ports.modem_control_reg1[MCR_OUT2_BIT];
    // R22 parallel enable
    p_en = ports.parallel_ctrl_reg[PCTL_IRQEN_BIT];
    sub_in = irq_in_raw;
    // R18 serial 1 after serial 0
    // R23 parallel applied last
    for (int i = 0; i < NUM_IN; i++) begin
      if (s0_en && route_slot(s0_field) == i) begin
        sub_in[i] = ports.serial0_irq;
      end
      // R17 serial 1 codes
      if (s1_en && route_slot(s1_field) == i) begin
        sub_in[i] = ports.serial1_irq;
      end
      if (p_en && route_slot(p_field) == i) begin
        sub_in[i] = ports.parallel_irq;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pulse stretching per input
  logic [15:0] ext_in;
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_in
      if (STRETCH_MASK[g]) begin : g_st
        logic act, act_out;
        // R7 low pulses widened
        // R8 irq8 high pulse widened
        assign act = POS_PULSE_MASK[g] ? sub_in[g] : !sub_in[g];
        // R9 lead and trail spans
        // R10 short opposite pulses hidden
        ismx_stretch #(
          .LEAD(LEAD),
          .TRAIL(TRAIL),
          .W(CNT_W)
        ) u_st (
          .clk(clk),
          .nrst(nrst),
          .ce(ce),
          .tick(tick),
          .active_in(act),
          .active_out(act_out)
        );
        assign ext_in[g] = POS_PULSE_MASK[g] ? act_out : !act_out;
      end else begin : g_pass
        // R11 no stretch
        assign ext_in[g] = sub_in[g];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // output multiplexer and pin drive
  logic out0_d, out1_d, oe0_d, oe1_d, irq7_d, irq7_oe_d;
  logic [7:0] line0, line1;

  always_comb begin
    // R4 line 0 order, irq8 inverted
    line0 = ext_in[SLOT_IRQ15:SLOT_IRQ8];
    line0[SLOT_IRQ8] = !ext_in[SLOT_IRQ8];
    // R5 line 1 order
    line1 = ext_in[SLOT_IRQ7:SLOT_IRQ12];
    out0_d = line0[mux_select_code];
    out1_d = line1[mux_select_code];
    oe0_d = 1'b1;
    oe1_d = 1'b1;
    irq7_d = 1'b0;
    irq7_oe_d = 1'b0;
    if (standalone) begin
      // R12 direct port interrupts
      // R13 enables from control bits
      out0_d = ports.serial0_irq;
      out1_d = ports.serial1_irq;
      oe0_d = ports.modem_control_reg0[MCR_OUT2_BIT];
      oe1_d = ports.modem_control_reg1[MCR_OUT2_BIT];
      irq7_d = ports.parallel_irq;
      irq7_oe_d = ports.parallel_ctrl_reg[PCTL_IRQEN_BIT];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_serial_out0 <= 1'b0;
      irq_serial_out1 <= 1'b0;
      irq_serial_out0_oe <= 1'b0;
      irq_serial_out1_oe <= 1'b0;
      irq7_out <= 1'b0;
      irq7_oe <= 1'b0;
      parallel_irq_style <= 1'b0;
      parallel_bus_style <= 1'b0;
      serial_fifo_mode <= 2'h0;
      ports_power_down <= 1'b0;
    end else if (ce) begin
      irq_serial_out0 <= out0_d;
      irq_serial_out1 <= out1_d;
      irq_serial_out0_oe <= oe0_d;
      irq_serial_out1_oe <= oe1_d;
      irq7_out <= irq7_d;
      irq7_oe <= irq7_oe_d;
      // R1 interrupt style
      parallel_irq_style <= port_mode_select_q[MODE_IRQ_BIT];
      // R2 bus style
      parallel_bus_style <= port_mode_select_q[MODE_BUS_BIT];
      // R3 fifo permit and enable
      serial_fifo_mode <= ports.port_fifo_enable
        & {2{port_mode_select_q[MODE_FIFO_BIT]}};
      ports_power_down <= port_mode_select_q[MODE_PUD_BIT];
    end
  end
endmodule

// ==== pkg/ismx_pkg.sv ====
package ismx_pkg;

  // local register addresses on the port-select bus
  localparam logic [2:0] ADDR_INDEX = 3'h3;
  localparam logic [2:0] ADDR_DATA = 3'h7;

  // indirect index values
  localparam logic [2:0] IDX_SER0_ROUTE = 3'h2;
  localparam logic [2:0] IDX_SER1_ROUTE = 3'h3;
  localparam logic [2:0] IDX_PAR_ROUTE = 3'h4;
  localparam logic [2:0] IDX_MODE = 3'h5;

  // port_mode_select field positions
  localparam int MODE_FIFO_BIT = 0;
  localparam int MODE_BUS_BIT = 1;
  localparam int MODE_IRQ_BIT = 2;
  localparam int MODE_PUD_BIT = 3;

  // modem control and parallel control bits
  localparam int MCR_OUT2_BIT = 3;
  localparam int MCR_LOOP_BIT = 4;
  localparam int PCTL_IRQEN_BIT = 4;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] ROUTE_FIELD_MASK = 4'hF;

  // route field codes
  localparam logic [3:0] RT_OFF = 4'h0;
  localparam logic [3:0] RT_IRQ3 = 4'h1;
  localparam logic [3:0] RT_IRQ4 = 4'h2;
  localparam logic [3:0] RT_IRQ5 = 4'h3;
  localparam logic [3:0] RT_IRQ6 = 4'h4;
  localparam logic [3:0] RT_IRQ7 = 4'h5;
  localparam logic [3:0] RT_IRQ10 = 4'h6;
  localparam logic [3:0] RT_IRQ11 = 4'h7;
  localparam logic [3:0] RT_ROM = 4'h8;
  localparam logic [3:0] RT_IRQ15 = 4'h9;
  localparam logic [3:0] RT_STANDALONE = 4'hF;

  // multiplexer input slots: out0 uses 0..7, out1 uses 8..15
  localparam int NUM_IN = 16;
  localparam int SLOT_IRQ8 = 0;
  localparam int SLOT_IRQ9 = 1;
  localparam int SLOT_IRQ10 = 2;
  localparam int SLOT_IRQ11 = 3;
  localparam int SLOT_ROM = 4;
  localparam int SLOT_RESET = 5;
  localparam int SLOT_IRQ14 = 6;
  localparam int SLOT_IRQ15 = 7;
  localparam int SLOT_IRQ12 = 8;
  localparam int SLOT_KBD = 9;
  localparam int SLOT_A20 = 10;
  localparam int SLOT_IRQ3 = 11;
  localparam int SLOT_IRQ4 = 12;
  localparam int SLOT_IRQ5 = 13;
  localparam int SLOT_IRQ6 = 14;
  localparam int SLOT_IRQ7 = 15;

  // extension: slots with stretching, and which are active-high pulses
  localparam logic [15:0] STRETCH_MASK = 16'hFBCF;
  localparam logic [15:0] POS_PULSE_MASK = 16'h0001;

  // stretch spans in rising edges of mux_select_lsb
  localparam int LEAD_EDGES = 5;
  localparam int TRAIL_EDGES = 3;
  localparam int CNT_W = 3;

  typedef struct packed {
    logic chip_sel;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ismx_bus_t;

  typedef struct packed {
    logic serial0_irq;
    logic serial1_irq;
    logic parallel_irq;
    logic [7:0] modem_control_reg0;
    logic [7:0] modem_control_reg1;
    logic [7:0] parallel_ctrl_reg;
    logic [1:0] port_fifo_enable;
  } ismx_port_t;

endpackage

// ==== rtl/ismx_stretch.sv ====
`timescale 1ns/1ps
module ismx_stretch #(
  parameter int LEAD = 5,
  parameter int TRAIL = 3,
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic tick,
  input wire logic active_in,
  output logic active_out
);
  // active_out holds while the lead or trail span still runs;
  // the idle level only passes after TRAIL ticks of idle input
  logic [W-1:0] lead_q, lead_d;
  logic [W-1:0] trail_q, trail_d;
  logic prev_q, prev_d;

  always_comb begin
    lead_d = lead_q;
    trail_d = trail_q;
    prev_d = active_in;
    if (active_in && !prev_q) begin
      lead_d = W'(LEAD);
    end else if (tick && lead_q != '0) begin
      lead_d = lead_q - 1'b1;
    end
    if (active_in) begin
      trail_d = W'(TRAIL);
    end else if (tick && trail_q != '0) begin
      trail_d = trail_q - 1'b1;
    end
    active_out = active_in || lead_q != '0 || trail_q != '0;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lead_q <= '0;
      trail_q <= '0;
      prev_q <= 1'b0;
    end else if (ce) begin
      lead_q <= lead_d;
      trail_q <= trail_d;
      prev_q <= prev_d;
    end
  end
endmodule

// ==== test/ismx_properties.sv ====
`timescale 1ns/1ps
module ismx_properties
  import ismx_pkg::*;
#(
  parameter int LEAD = 5,
  parameter int TRAIL = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire ismx_pkg::ismx_bus_t bus,
  input wire ismx_pkg::ismx_port_t ports,
  input wire logic [2:0] mux_select_code,
  input wire logic [15:0] irq_in_raw,
  input wire logic irq_serial_out0,
  input wire logic irq_serial_out0_oe,
  input wire logic irq_serial_out1,
  input wire logic irq_serial_out1_oe,
  input wire logic irq7_out,
  input wire logic irq7_oe,
  input wire logic [1:0] serial_fifo_mode
);
  import ismx_pkg::*;
  logic [2:0] idx_q, idx_d;
  logic [1:0] age_q, age_d;
  logic sa_q, sa_d;

  // shadow of the route state; age keeps checks quiet while writes land
  always_comb begin
    idx_d = idx_q;
    sa_d = sa_q;
    age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
    if (ce && bus.chip_sel && bus.wr) begin
      age_d = 2'h0;
      if (bus.addr == ADDR_INDEX) begin
        idx_d = bus.wdata[2:0];
      end else if (bus.addr == ADDR_DATA && idx_q == IDX_SER0_ROUTE) begin
        sa_d = bus.wdata[3:0] == RT_STANDALONE;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idx_q <= 3'h0;
      age_q <= 2'h0;
      sa_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      age_q <= age_d;
      sa_q <= sa_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence calm;
    // a frozen cycle leaves the outputs one step behind the ports
    age_q == 2'h3 && ce && $past(ce) && $stable(ports);
  endsequence

  sequence a20_held;
    (mux_select_code == 3'h2 && age_q == 2'h3 && !sa_q && ce
      && $stable(irq_in_raw[SLOT_A20]))[*4];
  endsequence

  chk_oe0_level: assert property (calm |-> irq_serial_out0_oe ==
    (sa_q ? ports.modem_control_reg0[MCR_OUT2_BIT] : 1'b1))
    else $error("out0 enable wrong");
  chk_oe1_level: assert property (calm |-> irq_serial_out1_oe ==
    (sa_q ? ports.modem_control_reg1[MCR_OUT2_BIT] : 1'b1))
    else $error("out1 enable wrong");
  chk_lpt_oe: assert property (calm |-> irq7_oe ==
    (sa_q & ports.parallel_ctrl_reg[PCTL_IRQEN_BIT]))
    else $error("irq7 enable wrong");
  chk_alone_out0: assert property (calm ##0 sa_q |->
    irq_serial_out0 == ports.serial0_irq)
    else $error("out0 not serial 0");
  chk_alone_out1: assert property (calm ##0 sa_q |->
    irq_serial_out1 == ports.serial1_irq)
    else $error("out1 not serial 1");
  chk_alone_lpt: assert property (calm ##0 sa_q |->
    irq7_out == ports.parallel_irq)
    else $error("irq7 not parallel");
  chk_fifo_gate: assert property (calm |->
    (serial_fifo_mode & ~ports.port_fifo_enable) == 2'h0)
    else $error("fifo mode without enable");
  chk_a20_pass: assert property (a20_held |->
    irq_serial_out1 == irq_in_raw[SLOT_A20])
    else $error("a20 gate not passed");
endmodule

// ==== test/ismx_ctrl_model.sv ====
`timescale 1ns/1ps
module ismx_ctrl_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic out0,
  input wire logic out1,
  output logic [2:0] code,
  output logic [7:0] seen0,
  output logic [7:0] seen1
);
  logic [1:0] cnt;

  // step codes, four cycles each so the registered lines settle
  always @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 2'h0;
      code <= 3'h0;
    end else begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h3) begin
        code <= code + 3'h1;
      end
    end
  end

  // sample both lines on the last cycle of a code
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen0 <= 8'h00;
      seen1 <= 8'h00;
    end else if (cnt == 2'h3) begin
      seen0[code] <= out0;
      seen1[code] <= out1;
    end
  end
endmodule

// ==== test/irq_serializing_mux_tb.sv ====
`timescale 1ns/1ps
module irq_serializing_mux_tb;
  import ismx_pkg::*;
  localparam logic [15:0] IDLE = 16'hFFFE;
  logic clk;
  logic nrst;
  logic ce;
  ismx_bus_t bus;
  ismx_port_t ports;
  logic [2:0] code;
  logic [15:0] raw;
  logic [7:0] rdata, seen0, seen1;
  logic [1:0] fifo;
  logic o0, oe0, o1, oe1, i7, i7oe, pis, pbs, pd;
  int failures;
  int cmp_count;

  ismx_top #(.LEAD(LEAD_EDGES), .TRAIL(TRAIL_EDGES)) u_ismx_top (
    .clk(clk), .nrst(nrst), .ce(ce), .bus(bus), .ports(ports),
    .mux_select_code(code), .irq_in_raw(raw), .rdata(rdata),
    .irq_serial_out0(o0), .irq_serial_out0_oe(oe0),
    .irq_serial_out1(o1), .irq_serial_out1_oe(oe1),
    .irq7_out(i7), .irq7_oe(i7oe), .parallel_irq_style(pis),
    .parallel_bus_style(pbs), .serial_fifo_mode(fifo),
    .ports_power_down(pd)
  );
  ismx_ctrl_model u_ismx_ctrl_model (
    .clk(clk), .nrst(nrst), .out0(o0), .out1(o1), .code(code),
    .seen0(seen0), .seen1(seen1)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one strobe cycle; address and data stay put after release
  task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    bus = {1'b1, r, ~r, a, d};
    @(negedge clk);
    bus = {3'h0, a, d};
  endtask

  // callers keep bits 7-4 zero and use legal codes only
  task automatic wreg(input logic [2:0] i, input logic [7:0] d);
    acc(1'b0, ADDR_INDEX, {5'h00, i});
    acc(1'b0, ADDR_DATA, d);
  endtask

  task automatic rreg(input logic [2:0] i, output logic [7:0] d);
    acc(1'b0, ADDR_INDEX, {5'h00, i});
    acc(1'b1, ADDR_DATA, 8'h00);
    @(negedge clk);
    d = rdata;
  endtask

  function automatic logic pick(input int s);
    return (s < 8) ? seen0[s] : seen1[s - 8];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] d;
    for (int i = 2; i < 7; i++) begin
      rreg(i[2:0], d);
      chk(d, REG_RESET);
      wreg(i[2:0], 8'h09);
      rreg(i[2:0], d);
      chk(d, (i < 6) ? 8'h09 : 8'h00);
      wreg(i[2:0], REG_RESET);
    end
  endtask

  // with ce low neither the index nor the data write may land
  task automatic t_freeze;
    logic [7:0] d;
    ce = 1'b0;
    wreg(IDX_SER1_ROUTE, 8'h05);
    ce = 1'b1;
    rreg(IDX_SER1_ROUTE, d);
    chk(d, REG_RESET);
  endtask

  task automatic t_mode;
    for (int m = 0; m < 64; m++) begin
      wreg(IDX_MODE, {4'h0, m[5:2]});
      ports.port_fifo_enable = m[1:0];
      repeat (2) @(negedge clk);
      chk({pd, pis, pbs, fifo}, {m[5:3], m[1:0] & {2{m[2]}}});
    end
    wreg(IDX_MODE, REG_RESET);
  endtask

  task automatic t_map(input logic [15:0] p);
    raw = p;
    repeat (160) @(negedge clk);
    chk({seen1, seen0}, {p[15:8], p[7:1], ~p[0]});
  endtask

  // pulse lands just after code 3 was sampled, so the next sample of
  // code 3 comes four select ticks later, inside the five-tick stretch;
  // a w of 16 spans the code 6 sample but only two select ticks
  task automatic t_pulse(input int s, input int w, input logic n,
    input logic f);
    @(posedge clk iff code == 3'h4);
    @(negedge clk);
    raw[s] = ~raw[s];
    repeat (w) @(negedge clk);
    raw[s] = ~raw[s];
    repeat (32 - w) @(negedge clk);
    chk(pick(s), n);
    repeat (96) @(negedge clk);
    chk(pick(s), f);
  endtask

  // does the slot follow port w's interrupt
  task automatic follow(input int w, input int s, input logic e);
    logic a;
    {ports.serial0_irq, ports.serial1_irq, ports.parallel_irq} = 3'h0;
    repeat (160) @(negedge clk);
    a = pick(s);
    {ports.serial0_irq, ports.serial1_irq, ports.parallel_irq} = 3'h4 >> w;
    repeat (160) @(negedge clk);
    chk(a ^ pick(s), e);
  endtask

  task automatic t_route;
    int sl[9] = '{11, 12, 13, 14, 15, 2, 3, 4, 7};
    ports.modem_control_reg0 = 8'h08;
    ports.modem_control_reg1 = 8'h08;
    ports.parallel_ctrl_reg = 8'h10;
    for (int w = 0; w < 3; w++) begin
      for (int c = 1; c < 10; c++) begin
        wreg(IDX_SER0_ROUTE + w[2:0], c[7:0]);
        follow(w, sl[c - 1], 1'b1);
      end
      wreg(IDX_SER0_ROUTE + w[2:0], 8'h00);
    end
    wreg(IDX_SER0_ROUTE, 8'h09);
    ports.modem_control_reg0 = 8'h18;
    follow(0, 7, 1'b0);
    ports.modem_control_reg0 = 8'h08;
    wreg(IDX_SER1_ROUTE, 8'h09);
    follow(0, 7, 1'b0);
    wreg(IDX_PAR_ROUTE, 8'h09);
    follow(1, 7, 1'b0);
    ports.parallel_ctrl_reg = 8'h00;
    follow(2, 7, 1'b0);
    follow(1, 7, 1'b1);
  endtask

  task automatic t_alone;
    chk({oe0, oe1, i7oe}, 3'h6);
    wreg(IDX_SER0_ROUTE, {4'h0, RT_STANDALONE});
    for (int i = 0; i < 8; i++) begin
      {ports.serial0_irq, ports.serial1_irq, ports.parallel_irq} = i[2:0];
      ports.modem_control_reg0 = {4'h0, ~i[0], 3'h0};
      ports.modem_control_reg1 = {4'h0, i[1], 3'h0};
      ports.parallel_ctrl_reg = {3'h0, i[2] ^ i[0], 4'h0};
      repeat (2) @(negedge clk);
      chk({o0, o1, i7, oe0, oe1, i7oe},
        {i[2:0], ~i[0], i[1], i[2] ^ i[0]});
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    end_sim;
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    ce = 1'b1;
    nrst = 1'b0;
    bus = '0;
    ports = '0;
    raw = IDLE;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    t_regs;
    t_freeze;
    t_mode;
    t_map(16'hA5C3);
    t_map(16'h5A3C);
    raw = IDLE;
    t_pulse(11, 1, 1'b0, 1'b1);
    t_pulse(0, 1, 1'b0, 1'b1);
    t_pulse(10, 1, 1'b1, 1'b1);
    raw[14] = 1'b0;
    t_pulse(14, 16, 1'b0, 1'b0);
    raw = IDLE;
    t_route;
    t_alone;
    end_sim;
  end
endmodule

bind ismx_top ismx_properties #(.LEAD(LEAD), .TRAIL(TRAIL)) u_ismx_properties (
  .clk, .nrst, .ce, .bus, .ports, .mux_select_code, .irq_in_raw,
  .irq_serial_out0, .irq_serial_out0_oe, .irq_serial_out1,
  .irq_serial_out1_oe, .irq7_out, .irq7_oe, .serial_fifo_mode
);
